// ---- rtl/tdchac_top.sv ----
// Purpose: Hit operand selection, ALU, timeout and interrupt control
// Assumes: Start and stop pins are asynchronous and synchronised here
// Notes:   Time stamps are core clock counts since ST_MEAS was entered

module tdchac_top (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  // Register port
  input  wire tdchac_pkg::tdchac_bus_type  bus_i,
  output logic      [31:0]                 rdata_o,
  // Measurement pins
  input  wire tdchac_pkg::tdchac_pins_type pins_i,
  input  wire logic                        cmp_out_i,
  // Front end control
  output logic                             analog_en_o,
  output logic                             load_capacitor_o,
  output logic                             autocal_o,
  // Interrupt
  output logic                             irq_o
);
  import tdchac_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [31:0]      ctrl_reg;
  logic [7:0]       hitsel_reg;
  logic [NIRQ-1:0]  stat_reg;
  logic [NIRQ-1:0]  stat_next;
  logic [NIRQ-1:0]  mask_reg;
  logic             irq_hold_reg;
  tdchac_state_type state_reg;
  tdchac_state_type state_next;
  logic [CNT_W-1:0] tick_reg;
  logic [CNT_W-1:0] stamp_a_reg [HITS_PER_CH];
  logic [CNT_W-1:0] stamp_b_reg [HITS_PER_CH];
  logic [2:0]       cnt_a_reg;
  logic [2:0]       cnt_b_reg;
  logic [31:0]      res_reg [NRES];
  logic             alu_go_reg;
  logic [2:0]       pin_s1_reg;
  logic [2:0]       pin_s2_reg;
  logic [2:0]       pin_d_reg;
  logic [2:0]       edge_w;
  logic             stop_a_w;
  logic             stop_b_w;
  logic             hits_met_w;
  logic             timeout_w;
  logic [CNT_W-1:0] timo_cyc_w;
  logic [CNT_W-1:0] chg_cyc_w;
  logic [31:0]      rd_w;
  logic [31:0]      nvm_rd_w;
  logic             nvm_done_w;
  logic             nvm_busy_w;
  logic             cmd_w;
  logic [31:0]      rdata_reg;
  logic [2:0]       exp_a_w;
  logic [2:0]       exp_b_w;

  // Time stamp of an operand source, start reads as zero
  function automatic logic [CNT_W-1:0] stamp_of(input logic [3:0] src,
      input logic [CNT_W-1:0] sa [HITS_PER_CH],
      input logic [CNT_W-1:0] sb [HITS_PER_CH]);
    logic [CNT_W-1:0] v;
    v = '0;
    if (src >= SRC_A1 && src < SRC_B1) begin
      v = sa[2'(src - SRC_A1)];
    end else if (src >= SRC_B1 && src <= SRC_B4) begin
      v = sb[2'(src - SRC_B1)];
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      pin_d_reg  <= 3'h0;
    end else begin
      pin_s1_reg <= {pins_i.start, pins_i.stop_a, pins_i.stop_b};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  assign edge_w = pin_s2_reg & ~pin_d_reg;
  // Analog path feeds channel a from comparator when front end is on
  assign stop_a_w = ctrl_reg[CTRL_ANALOG] ? edge_w[1] && cmp_out_i
                                          : edge_w[1];
  assign stop_b_w = edge_w[0];

  // ------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------
  assign analog_en_o = ctrl_reg[CTRL_ANALOG];
  assign autocal_o = ctrl_reg[CTRL_AUTOCAL];
  assign exp_a_w = ctrl_reg[CTRL_MODE2] ? 3'(MODE2_HITS)
                 : ctrl_reg[18:16];
  assign exp_b_w = ctrl_reg[CTRL_MODE2] ? 3'h0 : ctrl_reg[22:20];
  assign hits_met_w = (cnt_a_reg >= exp_a_w) && (cnt_b_reg >= exp_b_w);

  // Charge time choice, 300 us at reset
  always_comb begin
    case (ctrl_reg[CTRL_CHG_LO +: 2])
      2'd0: chg_cyc_w = CNT_W'(CHG_90_CYC);
      2'd1: chg_cyc_w = CNT_W'(CHG_120_CYC);
      2'd2: chg_cyc_w = CNT_W'(CHG_150_CYC);
      default: chg_cyc_w = CNT_W'(CHG_300_CYC);
    endcase
  end

  // Timeout window 64, 128, 256 or 1024 us
  always_comb begin
    case (ctrl_reg[CTRL_TIMO_LO +: 2])
      2'd0: timo_cyc_w = CNT_W'(TIMO_MIN_CYC);
      2'd1: timo_cyc_w = CNT_W'(TIMO_MIN_CYC * 2);
      2'd2: timo_cyc_w = CNT_W'(TIMO_MIN_CYC * 4);
      default: timo_cyc_w = CNT_W'(TIMO_MAX_US * CLK_MHZ);
    endcase
  end

  // Mode 1 has a fixed converter range at the counter top
  assign timeout_w = (state_reg == ST_MEAS) && (ctrl_reg[CTRL_MODE2]
                   ? tick_reg >= timo_cyc_w
                   : tick_reg == {CNT_W{1'b1}});

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  assign cmd_w = bus_i.wr && bus_i.addr == ADDR_CMD;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg   <= CTRL_RESET;
      hitsel_reg <= 8'h10;
      mask_reg   <= 4'h0;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_CTRL: ctrl_reg <= bus_i.wdata;
        ADDR_HITSEL: hitsel_reg <= bus_i.wdata[7:0];
        ADDR_IRQ_MASK: mask_reg <= bus_i.wdata[NIRQ-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Measurement sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_w && bus_i.wdata[CMD_INIT]) begin
          state_next = ctrl_reg[CTRL_ANALOG] ? ST_CHARGE : ST_MEAS;
        end
      end
      ST_CHARGE: begin
        if (tick_reg >= chg_cyc_w) begin
          state_next = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (hits_met_w || timeout_w) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (cmd_w && bus_i.wdata[CMD_INIT]) begin
          state_next = ctrl_reg[CTRL_ANALOG] ? ST_CHARGE : ST_MEAS;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Tick counter restarts on each state change and stops at its top value
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_reg <= '0;
    end else if (state_next != state_reg) begin
      tick_reg <= '0;
    end else if (tick_reg != {CNT_W{1'b1}}) begin
      tick_reg <= tick_reg + CNT_W'(1);
    end
  end

  assign load_capacitor_o = (state_reg == ST_CHARGE);

  // ------------------------------------------------------------
  // Stop time stamps per channel
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_a_reg <= 3'h0;
      cnt_b_reg <= 3'h0;
      for (int i = 0; i < HITS_PER_CH; i++) begin
        stamp_a_reg[i] <= '0;
        stamp_b_reg[i] <= '0;
      end
    end else if (state_next == ST_MEAS && state_reg != ST_MEAS) begin
      cnt_a_reg <= 3'h0;
      cnt_b_reg <= 3'h0;
    end else if (state_reg == ST_MEAS) begin
      if (stop_a_w && cnt_a_reg < 3'(HITS_PER_CH)) begin
        stamp_a_reg[2'(cnt_a_reg)] <= tick_reg;
        cnt_a_reg <= cnt_a_reg + 3'h1;
      end
      if (stop_b_w && cnt_b_reg < 3'(HITS_PER_CH)) begin
        stamp_b_reg[2'(cnt_b_reg)] <= tick_reg;
        cnt_b_reg <= cnt_b_reg + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // ALU: runs one cycle after the hit count ends the measurement, not on timeout
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alu_go_reg <= 1'b0;
    end else begin
      alu_go_reg <= (state_reg == ST_MEAS) && (state_next == ST_DONE)
                    && !timeout_w;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    logic [CNT_W-1:0] opa;
    logic [CNT_W-1:0] opb;
    logic [CNT_W+1:0] sum;
    if (!nrst_i) begin
      for (int i = 0; i < NRES; i++) begin
        res_reg[i] <= 32'h0000_0000;
      end
    end else if (alu_go_reg) begin
      opa = stamp_of(hitsel_reg[3:0], stamp_a_reg, stamp_b_reg);
      opb = stamp_of(hitsel_reg[7:4], stamp_a_reg, stamp_b_reg);
      if (ctrl_reg[CTRL_MODE2]) begin
        // Operand a is start (zero); b limited to channel a hits 1..3
        if (ctrl_reg[CTRL_AUTOSUM]) begin
          sum = '0;
          for (int i = 0; i < MODE2_HITS; i++) begin
            res_reg[i] <= 32'(stamp_a_reg[i]);
            sum = sum + (CNT_W+2)'(stamp_a_reg[i]);
          end
          res_reg[NRES-1] <= 32'(sum);
        end else begin
          opb = (hitsel_reg[7:4] >= SRC_A1 && hitsel_reg[7:4] <= 4'h3)
              ? opb : stamp_a_reg[0];
          res_reg[0] <= 32'(opb) - 32'(stamp_of(SRC_START, stamp_a_reg,
                        stamp_b_reg));
        end
      end else begin
        res_reg[0] <= 32'(opa) - 32'(opb);
      end
    end
  end

  // ------------------------------------------------------------
  // Nonvolatile identifier store
  // ------------------------------------------------------------
  tdchac_nvm u_nvm (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .store_i  (cmd_w && bus_i.wdata[CMD_NVM_STORE]),
    .recall_i (cmd_w && bus_i.wdata[CMD_NVM_RECALL]),
    .widx_i   (bus_i.addr[2:0]),
    .wdata_i  (bus_i.wdata),
    .wen_i    (bus_i.wr && bus_i.addr[4:3] == ADDR_NVM0[4:3]
               && bus_i.addr[2:0] != 3'h7),
    .ridx_i   (bus_i.addr[2:0]),
    .rdata_o  (nvm_rd_w),
    .busy_o   (nvm_busy_w),
    .done_o   (nvm_done_w)
  );

  // ------------------------------------------------------------
  // Interrupt status, mask and output
  // ------------------------------------------------------------
  always_comb begin
    stat_next = stat_reg;
    if (bus_i.wr && bus_i.addr == ADDR_IRQ_STAT) begin
      stat_next = stat_reg & ~bus_i.wdata[NIRQ-1:0];
    end
    // Events set after clear so a same-cycle event wins
    if (timeout_w) stat_next[IRQ_TIMEOUT] = 1'b1;
    if (state_reg == ST_MEAS && hits_met_w) begin
      stat_next[IRQ_HITS] = 1'b1;
    end
    if (alu_go_reg) stat_next[IRQ_ALU] = 1'b1;
    if (nvm_done_w) stat_next[IRQ_NVM] = 1'b1;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Held until init command restarts the measurement
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_hold_reg <= 1'b0;
    end else if (|(stat_next & mask_reg)) begin
      irq_hold_reg <= 1'b1;
    end else if (cmd_w && bus_i.wdata[CMD_INIT]) begin
      irq_hold_reg <= 1'b0;
    end
  end

  assign irq_o = irq_hold_reg | (|(stat_reg & mask_reg));

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_comb begin
    rd_w = 32'h0000_0000;
    case (bus_i.addr)
      ADDR_CTRL: rd_w = ctrl_reg;
      ADDR_HITSEL: rd_w = {24'h00_0000, hitsel_reg};
      ADDR_STATUS: rd_w = {20'h0_0000, 1'b0, nvm_busy_w, cnt_b_reg,
                           cnt_a_reg, state_reg};
      ADDR_IRQ_STAT: rd_w = {28'h000_0000, stat_reg};
      ADDR_IRQ_MASK: rd_w = {28'h000_0000, mask_reg};
      default: begin
        if (bus_i.addr >= ADDR_RES0
            && bus_i.addr < ADDR_RES0 + 5'(NRES)) begin
          rd_w = res_reg[3'(bus_i.addr - ADDR_RES0)];
        end else if (bus_i.addr >= ADDR_NVM0
                     && bus_i.addr < ADDR_NVM0 + 5'(NVM_WORDS)) begin
          rd_w = nvm_rd_w;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      rdata_reg <= rd_w;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_reg;
endmodule

// ---- rtl/tdchac_pkg.sv ----
// Purpose: Shared constants and types of the hit/ALU/interrupt control block
// Assumes: 200 MHz core clock
// Notes:   Offsets, cycle counts and the control reset value live here; other reset values sit in the modules

package tdchac_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CHG_90_US = 90;
  localparam int unsigned CHG_120_US = 120;
  localparam int unsigned CHG_150_US = 150;
  localparam int unsigned CHG_300_US = 300;
  localparam int unsigned TIMO_MIN_US = 64;
  localparam int unsigned TIMO_MAX_US = 1024;
  localparam int unsigned CHG_90_CYC = CHG_90_US * CLK_MHZ;
  localparam int unsigned CHG_120_CYC = CHG_120_US * CLK_MHZ;
  localparam int unsigned CHG_150_CYC = CHG_150_US * CLK_MHZ;
  localparam int unsigned CHG_300_CYC = CHG_300_US * CLK_MHZ;
  localparam int unsigned TIMO_MIN_CYC = TIMO_MIN_US * CLK_MHZ;
  localparam int unsigned CNT_W = 18;

  // ------------------------------------------------------------
  // Register map (word offsets of the plain port)
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_HITSEL = 5'h01;
  localparam logic [4:0] ADDR_STATUS = 5'h02;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h03;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h04;
  localparam logic [4:0] ADDR_CMD = 5'h05;
  localparam logic [4:0] ADDR_RES0 = 5'h08;
  localparam logic [4:0] ADDR_NVM0 = 5'h10;
  localparam int unsigned NVM_WORDS = 7;
  localparam int unsigned NRES = 5;

  // Control register fields
  localparam int unsigned CTRL_MODE2 = 0;
  localparam int unsigned CTRL_ANALOG = 1;
  localparam int unsigned CTRL_AUTOCAL = 2;
  localparam int unsigned CTRL_AUTOSUM = 3;
  localparam int unsigned CTRL_CHG_LO = 4;
  localparam int unsigned CTRL_TIMO_LO = 6;
  localparam int unsigned CTRL_HITA_LO = 8;
  localparam int unsigned CTRL_HITB_LO = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0030;

  // Command register bits
  localparam int unsigned CMD_INIT = 0;
  localparam int unsigned CMD_NVM_STORE = 1;
  localparam int unsigned CMD_NVM_RECALL = 2;

  // Interrupt bit positions
  localparam int unsigned IRQ_TIMEOUT = 0;
  localparam int unsigned IRQ_HITS = 1;
  localparam int unsigned IRQ_ALU = 2;
  localparam int unsigned IRQ_NVM = 3;
  localparam int unsigned NIRQ = 4;

  // Operand sources: 0 start, 1..4 channel a hits, 5..8 channel b hits
  localparam logic [3:0] SRC_START = 4'h0;
  localparam logic [3:0] SRC_A1 = 4'h1;
  localparam logic [3:0] SRC_B1 = 4'h5;
  localparam logic [3:0] SRC_B4 = 4'h8;
  localparam int unsigned HITS_PER_CH = 4;
  localparam int unsigned MODE2_HITS = 3;
  localparam int unsigned NVM_CYC = 64;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tdchac_bus_type;

  typedef struct packed {
    logic start;
    logic stop_a;
    logic stop_b;
  } tdchac_pins_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHARGE = 4'b0010,
    ST_MEAS = 4'b0100,
    ST_DONE = 4'b1000
  } tdchac_state_type;

endpackage

// ---- rtl/tdchac_nvm.sv ----
// Purpose: Seven-word nonvolatile store with timed transfer
// Assumes: Store and recall requests are single-cycle pulses
// Notes:   Shadow words are the live copy; transfer takes NVM_CYC cycles

module tdchac_nvm (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Requests
  input  wire logic        store_i,
  input  wire logic        recall_i,
  input  wire logic [2:0]  widx_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wen_i,
  // Answers
  input  wire logic [2:0]  ridx_i,
  output logic      [31:0] rdata_o,
  output logic             busy_o,
  output logic             done_o
);
  import tdchac_pkg::*;

  logic [31:0] shadow_reg [NVM_WORDS];
  logic [31:0] cell_reg [NVM_WORDS];
  logic [6:0]  cnt_reg;
  logic        dir_reg;

  // ------------------------------------------------------------
  // Transfer timer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 7'h00;
      dir_reg <= 1'b0;
    end else if (cnt_reg != 7'h00) begin
      cnt_reg <= cnt_reg - 7'h01;
    end else if (store_i || recall_i) begin
      cnt_reg <= 7'(NVM_CYC);
      dir_reg <= store_i;
    end
  end

  // Shadow written by host, loaded on recall end; cells on store end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NVM_WORDS; i++) begin
        shadow_reg[i] <= 32'h0000_0000;
        cell_reg[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < NVM_WORDS; i++) begin
        if (cnt_reg == 7'h01 && dir_reg) begin
          cell_reg[i] <= shadow_reg[i];
        end else if (cnt_reg == 7'h01) begin
          shadow_reg[i] <= cell_reg[i];
        end else if (wen_i && cnt_reg == 7'h00 && widx_i == 3'(i)) begin
          shadow_reg[i] <= wdata_i;
        end
      end
    end
  end

  assign busy_o = (cnt_reg != 7'h00);
  assign done_o = (cnt_reg == 7'h01);
  assign rdata_o = (ridx_i < 3'(NVM_WORDS)) ? shadow_reg[ridx_i]
                                            : 32'h0000_0000;
endmodule

// ---- tb/tdchac_assertions.sv ----
// Purpose: Port checks of the hit/ALU/interrupt block
// Assumes: Host strobes are single-cycle pulses
// Notes:   Shadows track host writes to mask and control
module tdchac_assertions
  import tdchac_pkg::*;
(
  // Watched ports
  input wire logic                       clk_i,
  input wire logic                       nrst_i,
  input wire tdchac_pkg::tdchac_bus_type bus_i,
  input wire logic [31:0]                rdata_o,
  input wire logic                       analog_en_o,
  input wire logic                       load_capacitor_o,
  input wire logic                       autocal_o,
  input wire logic                       irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [31:0]      mask_reg;
  logic [31:0]      ctrl_reg;
  logic [CNT_W-1:0] chg_cnt;
  // Write shadows and charge length count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_reg <= '0;
      ctrl_reg <= CTRL_RESET;
      chg_cnt <= '0;
    end else begin
      if (bus_i.wr && bus_i.addr == ADDR_IRQ_MASK) mask_reg <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == ADDR_CTRL) ctrl_reg <= bus_i.wdata;
      chg_cnt <= load_capacitor_o ? chg_cnt + 1'b1 : '0;
    end
  end
  // Init command write
  sequence s_init;
    bus_i.wr && bus_i.addr == ADDR_CMD && bus_i.wdata[CMD_INIT];
  endsequence
  property p_rd_idle;
    !$past(bus_i.rd) |-> rdata_o == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_ctrl_rd;
    bus_i.rd && bus_i.addr == ADDR_CTRL
      |=> rdata_o[3:0] == $past(ctrl_reg[3:0]);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("ctrl readback");
  property p_analog;
    analog_en_o == ctrl_reg[CTRL_ANALOG];
  endproperty
  a_analog: assert property (p_analog) else $error("analog enable");
  property p_autocal;
    autocal_o == ctrl_reg[CTRL_AUTOCAL];
  endproperty
  a_autocal: assert property (p_autocal) else $error("autocal");
  property p_cap_max;
    chg_cnt <= CHG_300_CYC;
  endproperty
  a_cap_max: assert property (p_cap_max)
    else $error("charge too long");
  property p_cap_analog;
    load_capacitor_o |-> analog_en_o;
  endproperty
  a_cap_analog: assert property (p_cap_analog)
    else $error("charge without analog");
  property p_irq_mask;
    $rose(irq_o) |-> mask_reg[NIRQ-1:0] != '0;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq while masked");
  property p_irq_hold;
    irq_o && !(bus_i.wr && bus_i.addr == ADDR_CMD) |=> irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped");
  property p_irq_clr;
    s_init |=> !irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("irq not cleared");
endmodule
bind tdchac_top tdchac_assertions tdchac_assertions_inst (
  .clk_i, .nrst_i, .bus_i, .rdata_o, .analog_en_o, .load_capacitor_o,
  .autocal_o, .irq_o);

// ---- tb/tdchac_hit_src.sv ----
// Purpose: Far-side stop source driving channel a
// Assumes: go_i is a one-cycle request
// Notes:   Rising edges come gap_i cycles apart, high for 4 cycles
module tdchac_hit_src (
  // Clock and request
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] gap_i,
  input  wire logic [2:0]  num_i,
  // Stop line
  output logic             stop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial stop_o = 1'b0;
  // Emit the requested pulse train
  always @(posedge clk_i) begin
    if (go_i) begin
      for (int i = 0; i < num_i; i++) begin
        repeat (gap_i - 4) @(posedge clk_i);
        stop_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        stop_o <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/tdc_hit_alu_interrupt_control_tb_top.sv ----
// Purpose: Self-checking bench of the hit/ALU/interrupt block
// Assumes: Stop pulses come from the hit source model
// Notes:   Start and channel b pins held low, comparator high
module tdc_hit_alu_interrupt_control_tb_top import tdchac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk_i = 1'b0;
  logic           nrst_i = 1'b0;
  tdchac_bus_type bus = '0;
  logic [31:0]    rdata, v, r [NRES];
  logic           an_en, cap, acal, irq, stop_a, go = 1'b0;
  logic [15:0]    gap = 16'h0000;
  logic [2:0]     num = 3'h0;
  int             n_mismatch = 0, comparisons = 0, n;
  initial forever #2.5 clk_i = ~clk_i;
  tdchac_top tdchac_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus),
    .rdata_o(rdata), .pins_i({1'b0, stop_a, 1'b0}), .cmp_out_i(1'b1),
    .analog_en_o(an_en), .load_capacitor_o(cap), .autocal_o(acal),
    .irq_o(irq));
  tdchac_hit_src tdchac_hit_src_inst (.clk_i(clk_i), .go_i(go),
    .gap_i(gap), .num_i(num), .stop_o(stop_a));
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [4:0] a);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_i);
  endtask
  // Bounded wait for the interrupt line
  task automatic wt(input int lim);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > lim) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  task automatic fire(input logic [15:0] g, input logic [2:0] k);
    gap <= g;
    num <= k;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic t_regs();
    rd(ADDR_CTRL); chk(v, CTRL_RESET);
    rd(ADDR_HITSEL); chk(v, 32'h0000_0010);
    rd(5'h06); chk(v, 32'h0000_0000);
  endtask
  task automatic t_mode1();
    wr(ADDR_CTRL, 32'h0002_0000);
    wr(ADDR_HITSEL, 32'h0000_0012);
    wr(ADDR_IRQ_MASK, 32'h0000_0006);
    wr(ADDR_CMD, 32'h0000_0001);
    fire(16'h0028, 3'h2);
    wt(200); repeat (3) @(posedge clk_i);
    rd(ADDR_RES0); chk(v, 32'h0000_0028);
    rd(ADDR_IRQ_STAT); chk(v, 32'h0000_0006);
    wr(ADDR_IRQ_STAT, 32'h0000_0006);
    rd(ADDR_IRQ_STAT); chk(v, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
  endtask
  task automatic t_mode2();
    wr(ADDR_CTRL, 32'h0003_00C9);
    wr(ADDR_HITSEL, 32'h0000_0021);
    wr(ADDR_CMD, 32'h0000_0001);
    fire(16'h0032, 3'h3);
    wt(300); repeat (3) @(posedge clk_i);
    for (int i = 0; i < NRES; i++) begin
      rd(ADDR_RES0 + 5'(i));
      r[i] = v;
    end
    chk(r[1] - r[0], 32'h0000_0032);
    chk(r[2] - r[1], 32'h0000_0032);
    chk(r[4], r[0] + r[1] + r[2]);
  endtask
  task automatic t_nvm();
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0001);
    wr(ADDR_NVM0 + 5'h06, 32'h1234_5678);
    wr(ADDR_IRQ_STAT, 32'h0000_000F);
    wr(ADDR_CMD, 32'h0000_0002);
    repeat (80) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0000);
    rd(ADDR_IRQ_STAT); chk(v, 32'h0000_0008);
    wr(ADDR_IRQ_MASK, 32'h0000_0008);
    chk(32'(irq), 32'h0000_0001);
    wr(ADDR_NVM0 + 5'h06, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0004);
    repeat (80) @(posedge clk_i);
    rd(ADDR_NVM0 + 5'h06); chk(v, 32'h1234_5678);
  endtask
  task automatic t_timeout();
    wr(ADDR_CTRL, 32'h0003_0001);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    wr(ADDR_IRQ_STAT, 32'h0000_000F);
    wr(ADDR_CMD, 32'h0000_0001);
    wt(14000);
    chk(32'(n > TIMO_MIN_CYC - 8 && n < TIMO_MIN_CYC + 8), 32'h1);
    rd(ADDR_IRQ_STAT); chk(v, 32'h0000_0001);
  endtask
  task automatic t_analog();
    wr(ADDR_CTRL, 32'h0000_0006);
    chk({30'h0, an_en, acal}, 32'h0000_0003);
    wr(ADDR_IRQ_STAT, 32'h0000_000F);
    wr(ADDR_CMD, 32'h0000_0001);
    n = 0;
    while (cap !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    if (cap !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    n = 0;
    while (cap === 1'b1 && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n > CHG_90_CYC - 2 && n < CHG_90_CYC + 2), 32'h1);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_mode1();
    t_mode2();
    t_nvm();
    t_timeout();
    t_analog();
    end_of_test();
  end
endmodule
